/* File: pkg/cli_pkg.sv */
/*
  Constants and carrier types for the character display instruction decoder.
  Assumes a 100 MHz pclk; busy times are derived from an internal oscillator
  tick at the documented 540 kHz.
*/
package cli_pkg;

  // ***************************************************************
  // Clock and timing
  // ***************************************************************
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned OSC_KHZ = 540;
  // Oscillator tick divider in pclk cycles (rounded down).
  localparam int unsigned OSC_DIV = CLK_HZ / (OSC_KHZ * 1000);
  localparam int unsigned CLEAR_TIME_US100 = 164;
  localparam int unsigned CMD_TIME_US = 40;
  localparam int unsigned STATUS_TIME_US = 1;
  // Busy lengths in oscillator ticks.
  localparam int unsigned CLEAR_TICKS = (CLEAR_TIME_US100 * OSC_KHZ + 99) / 100;
  localparam int unsigned CMD_TICKS = (CMD_TIME_US * OSC_KHZ + 999) / 1000;
  localparam int unsigned STATUS_TICKS = 1;

  // ***************************************************************
  // Register map (APB byte addresses)
  // ***************************************************************
  localparam logic [11:0] ADDR_CMD = 12'h000;
  localparam logic [11:0] ADDR_DATA = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_MODE = 12'h00C;
  localparam logic [11:0] ADDR_GLYPH = 12'h010;

  // ***************************************************************
  // Reset values and sizes
  // ***************************************************************
  localparam int unsigned DISP_RAM_WORDS = 128;
  localparam int unsigned GLYPH_RAM_WORDS = 64;
  localparam logic [6:0] AC_RESET = 7'h00;
  localparam logic [7:0] CLEAR_CODE = 8'h20;
  localparam logic [4:0] COMMON_8 = 5'h08;
  localparam logic [4:0] COMMON_11 = 5'h0B;
  localparam logic [4:0] COMMON_16 = 5'h10;

  // Mode fields set by instructions.
  typedef struct packed {
    logic increment;
    logic shift_on;
    logic display_on;
    logic cursor_on;
    logic blink_on;
    logic bus_width_select;
    logic two_lines;
    logic font_tall;
  } cli_mode_type;

  // One decoded host access.
  typedef struct packed {
    logic reg_select;
    logic read_write_sel;
    logic [7:0] value;
  } cli_access_type;

endpackage

/* File: src/cli_glyph_map.sv */
/*
  Glyph source selector: maps a character code to glyph RAM or ROM.
  Assumes the caller provides the row number of the glyph being scanned.
*/
`timescale 1ns/1ps
module cli_glyph_map (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] char_code,
  input wire logic [3:0] row,
  output logic from_ram_q,
  output logic [5:0] ram_addr_q,
  output logic [7:0] rom_index_q
);

  // Registers the lookup; bit 3 is dropped for glyph RAM codes. [R16]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      from_ram_q <= 1'b0;
      ram_addr_q <= 6'h00;
      rom_index_q <= 8'h00;
    end else begin
      from_ram_q <= (char_code[7:4] == 4'h0); // [R16]
      ram_addr_q <= {char_code[2:0], row[2:0]}; // [R16]
      // Column from the upper nibble, row from the lower. [R17]
      rom_index_q <= {char_code[7:4], char_code[3:0]};
    end
  end

endmodule

/* File: src/cli_decoder.sv */
/*
  Instruction decoder and host port of a character display controller,
  reached over APB. Writes to CMD are instructions, DATA holds data access.
  Assumes APB master follows the protocol; one pclk domain.
*/
// Function
// R1: Clear code fills display RAM, cancels shift, address counter to zero.
// R2: Home cancels shift and zeros address counter, memory kept.
// R3: Entry mode stores increment and shift-on, applied after data accesses.
// R4: Display control latches display, cursor and blink enables.
// R5: Shift moves display or cursor, direction from bit 2.
// R6: Function set stores bus width, line count and font.
// R7: Glyph address set loads six bits and selects glyph RAM.
// R8: Display address set loads seven bits and selects display RAM.
// R9: Status read returns busy flag and address counter.
// R10: Data write stores to last addressed RAM.
// R11: Data read returns byte at current address.
// R12: Busy flag is one while an operation runs.
// R13: Don't-care instruction bits are ignored.
// R14: Busy length counted in oscillator ticks.
// R15: Host writes the model's fixed line-count value.
// R16: Codes with upper nibble zero select eight glyph RAM patterns.
// R17: Glyph lookup uses upper nibble as column, lower as row.
// R18: Line count and font set common count and duty.
// R19: Host polls busy or waits before next access.
// R20: In 4-bit mode a byte moves as two nibbles, upper first.
`timescale 1ns/1ps
module cli_decoder #(
  parameter int unsigned OSC_DIV = cli_pkg::OSC_DIV
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] scan_code,
  input wire logic [3:0] scan_row,
  output logic [4:0] common_count,
  output logic display_on,
  output logic glyph_from_ram,
  output logic [5:0] glyph_ram_addr,
  output logic [7:0] glyph_rom_index
);

  // ***************************************************************
  // State
  // ***************************************************************
  typedef enum logic [2:0] {
    CLI_IDLE = 3'b001,
    CLI_BUSY = 3'b010,
    CLI_CLEAR = 3'b100
  } cli_state_type;

  cli_state_type state_q;
  cli_pkg::cli_mode_type mode_q;
  logic [6:0] address_counter_q;
  logic glyph_sel_q;
  logic [6:0] shift_q;
  logic [15:0] busy_ticks_q;
  logic [15:0] div_q;
  logic osc_tick;
  logic [6:0] clear_idx_q;
  logic nibble_phase_q;
  logic [3:0] nibble_hold_q;
  logic [7:0] read_buf_q;
  logic [7:0] display_ram [0:cli_pkg::DISP_RAM_WORDS-1];
  logic [7:0] glyph_ram [0:cli_pkg::GLYPH_RAM_WORDS-1];
  logic busy_flag;
  logic wr_acc;
  logic rd_acc;
  logic byte_done;
  logic [7:0] byte_val;
  logic is_cmd;
  logic is_data;
  logic [7:0] data_rd;

  // Address counter step in the entry-mode direction.
  function automatic logic [6:0] step(input logic [6:0] a, input logic inc);
    step = inc ? 7'(a + 7'h01) : 7'(a - 7'h01);
  endfunction

  // True when a host transfer carries a whole byte or opens a 4-bit pair;
  // false for the second transfer that closes the pair. [R20]
  function automatic logic byte_phase(input logic wide, input logic half);
    byte_phase = wide || !half;
  endfunction

  // Busy state and the access decode shared by the processes below.
  assign busy_flag = (state_q != CLI_IDLE); // [R12]
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign is_cmd = (paddr == cli_pkg::ADDR_CMD);
  assign is_data = (paddr == cli_pkg::ADDR_DATA);

  // ***************************************************************
  // Host byte assembly
  // ***************************************************************
  // Pairs two nibbles on bits 7:4 into one byte in 4-bit mode. [R20]
  always_comb begin
    byte_val = pwdata[7:0];
    byte_done = wr_acc && (is_cmd || is_data);
    if (!mode_q.bus_width_select) begin
      byte_val = {nibble_hold_q, pwdata[7:4]};
      byte_done = wr_acc && (is_cmd || is_data) && nibble_phase_q;
    end
  end

  // Tracks nibble phase; CMD and DATA reads and writes each toggle it in 4-bit mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nibble_phase_q <= 1'b0;
      nibble_hold_q <= 4'h0;
    end else if (psel && penable && (is_cmd || is_data) &&
                 !mode_q.bus_width_select) begin
      nibble_phase_q <= !nibble_phase_q; // [R20]
      if (!nibble_phase_q) begin
        nibble_hold_q <= pwdata[7:4];
      end
    end
  end

  // ***************************************************************
  // Oscillator tick
  // ***************************************************************
  // Divides pclk down to the internal oscillator rate. [R14]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 16'h0000;
    end else if (div_q == 16'(OSC_DIV - 1)) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= 16'(div_q + 16'h0001);
    end
  end
  assign osc_tick = (div_q == 16'(OSC_DIV - 1));

  // ***************************************************************
  // Instruction execution
  // ***************************************************************
  // Decodes by highest set bit; lower don't-care bits ignored. [R13]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= CLI_IDLE;
      mode_q <= '0;
      mode_q.increment <= 1'b1;
      mode_q.bus_width_select <= 1'b1;
      address_counter_q <= cli_pkg::AC_RESET;
      glyph_sel_q <= 1'b0;
      shift_q <= 7'h00;
      busy_ticks_q <= 16'h0000;
      clear_idx_q <= 7'h00;
    end else begin
      case (state_q)
        CLI_IDLE: begin
          if (byte_done && is_cmd) begin
            state_q <= CLI_BUSY;
            busy_ticks_q <= 16'(cli_pkg::CMD_TICKS); // [R14]
            if (byte_val[7]) begin
              address_counter_q <= byte_val[6:0]; // [R8]
              glyph_sel_q <= 1'b0;
            end else if (byte_val[6]) begin
              address_counter_q <= {1'b0, byte_val[5:0]}; // [R7]
              glyph_sel_q <= 1'b1;
            end else if (byte_val[5]) begin
              mode_q.bus_width_select <= byte_val[4]; // [R6]
              mode_q.two_lines <= byte_val[3]; // [R6] [R15]
              mode_q.font_tall <= byte_val[2];
            end else if (byte_val[4]) begin
              if (byte_val[3]) begin
                shift_q <= step(shift_q, !byte_val[2]); // [R5]
              end else begin
                address_counter_q <= step(address_counter_q,
                                          byte_val[2]); // [R5]
              end
            end else if (byte_val[3]) begin
              mode_q.display_on <= byte_val[2]; // [R4]
              mode_q.cursor_on <= byte_val[1];
              mode_q.blink_on <= byte_val[0];
            end else if (byte_val[2]) begin
              mode_q.increment <= byte_val[1]; // [R3]
              mode_q.shift_on <= byte_val[0];
            end else if (byte_val[1]) begin
              address_counter_q <= cli_pkg::AC_RESET; // [R2]
              glyph_sel_q <= 1'b0;
              shift_q <= 7'h00;
              busy_ticks_q <= 16'(cli_pkg::CLEAR_TICKS);
            end else if (byte_val[0]) begin
              address_counter_q <= cli_pkg::AC_RESET; // [R1]
              glyph_sel_q <= 1'b0;
              shift_q <= 7'h00;
              clear_idx_q <= 7'h00;
              busy_ticks_q <= 16'(cli_pkg::CLEAR_TICKS);
              state_q <= CLI_CLEAR;
            end
          end else if (psel && penable && is_data &&
                       (pwrite ? byte_done :
                        (mode_q.bus_width_select || nibble_phase_q))) begin
            // Data access moves the counter; a data write also moves the display if enabled.
            // A 4-bit read pair moves it once, on its second transfer. [R20]
            state_q <= CLI_BUSY;
            busy_ticks_q <= 16'(cli_pkg::CMD_TICKS);
            address_counter_q <= step(address_counter_q,
                                      mode_q.increment); // [R3]
            if (mode_q.shift_on && pwrite) begin
              shift_q <= step(shift_q, mode_q.increment);
            end
          end
        end
        CLI_CLEAR: begin
          clear_idx_q <= 7'(clear_idx_q + 7'h01); // [R1]
          if (osc_tick) begin
            busy_ticks_q <= 16'(busy_ticks_q - 16'h0001);
          end
          if (clear_idx_q == 7'h7F) begin
            state_q <= CLI_BUSY;
          end
        end
        CLI_BUSY: begin
          if (osc_tick) begin
            if (busy_ticks_q <= 16'h0001) begin
              state_q <= CLI_IDLE; // [R12]
            end else begin
              busy_ticks_q <= 16'(busy_ticks_q - 16'h0001);
            end
          end
        end
        default: begin
          state_q <= CLI_IDLE;
        end
      endcase
    end
  end

  // ***************************************************************
  // Memories
  // ***************************************************************
  // Writes data to the last addressed RAM, and clears display RAM. [R10]
  always_ff @(posedge pclk) begin
    if (state_q == CLI_CLEAR) begin
      display_ram[clear_idx_q] <= cli_pkg::CLEAR_CODE; // [R1]
    end else if (state_q == CLI_IDLE && byte_done && is_data) begin
      if (glyph_sel_q) begin
        glyph_ram[address_counter_q[5:0]] <= byte_val; // [R10]
      end else begin
        display_ram[address_counter_q] <= byte_val; // [R10]
      end
    end
  end

  assign data_rd = glyph_sel_q ? glyph_ram[address_counter_q[5:0]] :
                   display_ram[address_counter_q]; // [R11]

  // Latches the addressed byte so both nibbles come from one read.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_buf_q <= 8'h00;
    end else if (rd_acc && is_data && state_q == CLI_IDLE &&
                 byte_phase(mode_q.bus_width_select, nibble_phase_q)) begin
      read_buf_q <= data_rd;
    end
  end

  // ***************************************************************
  // APB slave
  // ***************************************************************
  // Answers every access in its first access cycle; reads registered.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable &&
                 !(is_cmd || is_data || paddr == cli_pkg::ADDR_STATUS ||
                   paddr == cli_pkg::ADDR_MODE ||
                   paddr == cli_pkg::ADDR_GLYPH);
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          cli_pkg::ADDR_CMD: begin
            // The second read of a 4-bit pair brings the low nibble. [R20]
            if (byte_phase(mode_q.bus_width_select, nibble_phase_q)) begin
              prdata <= {24'h00_0000, busy_flag, address_counter_q}; // [R9]
            end else begin
              prdata <= {24'h00_0000, address_counter_q[3:0], 4'h0};
            end
          end
          cli_pkg::ADDR_DATA: begin
            // The first read of a 4-bit pair brings data_rd, the second the low nibble of read_buf_q.
            if (byte_phase(mode_q.bus_width_select, nibble_phase_q)) begin
              prdata <= {24'h00_0000, data_rd}; // [R11]
            end else begin
              prdata <= {24'h00_0000, read_buf_q[3:0], 4'h0}; // [R20]
            end
          end
          cli_pkg::ADDR_STATUS: prdata <= {16'h0000, 1'b0, shift_q,
                                           7'h00, busy_flag};
          cli_pkg::ADDR_MODE: prdata <= {24'h00_0000, mode_q};
          cli_pkg::ADDR_GLYPH: prdata <= {16'h0000, glyph_rom_index,
                                          1'b0, glyph_from_ram,
                                          glyph_ram_addr};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ***************************************************************
  // Display outputs
  // ***************************************************************
  // Selects common count from line count and font. [R18]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      common_count <= cli_pkg::COMMON_8;
      display_on <= 1'b0;
    end else begin
      display_on <= mode_q.display_on;
      if (mode_q.two_lines) begin
        common_count <= cli_pkg::COMMON_16; // [R18]
      end else if (mode_q.font_tall) begin
        common_count <= cli_pkg::COMMON_11;
      end else begin
        common_count <= cli_pkg::COMMON_8;
      end
    end
  end

  // Glyph source lookup for the scanned character. [R17]
  cli_glyph_map u_map (
    .pclk(pclk),
    .presetn(presetn),
    .char_code(scan_code),
    .row(scan_row),
    .from_ram_q(glyph_from_ram),
    .ram_addr_q(glyph_ram_addr),
    .rom_index_q(glyph_rom_index)
  );

endmodule

/* File: testbench/cli_decoder_props.sv */
/*
  Port checker for the display instruction decoder.
  Assumes binding to every cli_decoder and an APB master that drops
  penable after each answer.
*/
`timescale 1ns/1ps
module cli_decoder_props #(
  parameter int unsigned OSC_DIV = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] scan_code,
  input wire logic [3:0] scan_row,
  input wire logic [4:0] common_count,
  input wire logic display_on,
  input wire logic glyph_from_ram,
  input wire logic [5:0] glyph_ram_addr,
  input wire logic [7:0] glyph_rom_index
);
  // All checks share the bus clock and its reset.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_zero_wait: assert property (psel && penable |-> pready)
    else $error("Access phase seen without ready.");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("Ready raised outside an access phase.");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("Read data not zero while idle.");
  a_err_unmapped: assert property (pready &&
    !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00C, 12'h010}) |-> pslverr)
    else $error("Unmapped address answered without error.");
  a_err_mapped: assert property (pready &&
    (paddr inside {12'h000, 12'h004, 12'h008, 12'h00C, 12'h010}) |-> !pslverr)
    else $error("Mapped address answered with error.");
  a_status_form: assert property (
    pready && !pwrite && paddr == 12'h000 |-> prdata[31:8] == 24'h00_0000)
    else $error("Status read carries stray upper bits.");
  a_glyph_ram: assert property (
    presetn |=> glyph_from_ram == ($past(scan_code[7:4]) == 4'h0))
    else $error("Glyph source select wrong.");
  a_glyph_addr: assert property (
    presetn |=>
      glyph_ram_addr == {$past(scan_code[2:0]), $past(scan_row[2:0])})
    else $error("Glyph RAM address wrong.");
  a_rom_index: assert property (
    presetn |=> glyph_rom_index == $past(scan_code))
    else $error("Glyph ROM index wrong.");
  a_common_legal: assert property (
    common_count inside {5'h08, 5'h0B, 5'h10})
    else $error("Common count not a legal duty.");
endmodule

bind cli_decoder cli_decoder_props #(.OSC_DIV(OSC_DIV)) u_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .scan_code, .scan_row, .common_count, .display_on,
  .glyph_from_ram, .glyph_ram_addr, .glyph_rom_index
);

/* File: testbench/cli_host_model.sv */
/*
  APB host model standing in for the microprocessor.
  Assumes a slave that answers within a few cycles.
*/
`timescale 1ns/1ps
module cli_host_model (
  input wire logic pclk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata
);
  int timeouts;

  // Bus idle at time zero.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    timeouts = 0;
  end

  // One transfer: setup, then access held until ready is sampled high.
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic er);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    if (n >= 16) timeouts++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Narrow bus: a byte goes as two nibbles, upper one first.
  task automatic nib_write(input logic [11:0] a, input logic [7:0] b);
    logic [31:0] rd;
    logic er;
    xfer(1'b1, a, {24'h00_0000, b[7:4], 4'h0}, rd, er);
    xfer(1'b1, a, {24'h00_0000, b[3:0], 4'h0}, rd, er);
  endtask
endmodule

/* File: testbench/testbench.sv */
/*
  Self-checking bench for the display instruction decoder.
  Assumes the bound checker and the APB host model.
*/
`timescale 1ns/1ps
module testbench;
  localparam int unsigned DIV = 2;
  localparam logic [11:0] A_CMD = cli_pkg::ADDR_CMD;
  localparam logic [11:0] A_DATA = cli_pkg::ADDR_DATA;
  localparam logic [11:0] A_MODE = cli_pkg::ADDR_MODE;
  localparam logic [11:0] A_STATUS = cli_pkg::ADDR_STATUS;
  typedef struct {
    logic [7:0] ins;
    logic [11:0] addr;
    logic [7:0] mask;
    logic [7:0] exp;
  } cli_row_type;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr;
  logic display_on, glyph_from_ram, last_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] scan_code = 8'h00;
  logic [7:0] glyph_rom_index;
  logic [3:0] scan_row = 4'h0;
  logic [4:0] common_count;
  logic [5:0] glyph_ram_addr;
  int mismatches, check_count, cyc;
  time t0;
  cli_row_type rows [13] = '{
    '{8'h0F, A_MODE, 8'h38, 8'h38}, '{8'h0C, A_MODE, 8'h38, 8'h20},
    '{8'h05, A_MODE, 8'hC0, 8'h40}, '{8'h06, A_MODE, 8'hC0, 8'h80},
    '{8'h3F, A_MODE, 8'h07, 8'h07}, '{8'h30, A_MODE, 8'h07, 8'h04},
    '{8'hC5, A_CMD, 8'h7F, 8'h45}, '{8'h14, A_CMD, 8'h7F, 8'h46},
    '{8'h13, A_CMD, 8'h7F, 8'h45}, '{8'h6A, A_CMD, 8'h7F, 8'h2A},
    '{8'h02, A_CMD, 8'h7F, 8'h00}, '{8'hFF, A_CMD, 8'h7F, 8'h7F},
    '{8'h03, A_CMD, 8'h7F, 8'h00}};

  cli_decoder #(.OSC_DIV(DIV)) uut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .scan_code,
    .scan_row, .common_count, .display_on, .glyph_from_ram,
    .glyph_ram_addr, .glyph_rom_index);
  cli_host_model u_host (.pclk, .prdata, .pready, .pslverr, .psel,
    .penable, .pwrite, .paddr, .pwdata);

  // Clock, and a scan stream that walks every code and row.
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    scan_code <= scan_code + 8'h01;
    scan_row <= scan_row + 4'h3;
  end

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Byte transfer; a hung bus ends the run.
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    u_host.xfer(w, a, {24'h00_0000, d}, rd, last_err);
    if (u_host.timeouts != 0) begin
      mismatches++;
      end_sim();
    end
  endtask

  // Polls the busy flag under a bound; counts cycles since t0.
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      bus(1'b0, A_CMD, 8'h00);
      n++;
    end while (rd[7] !== 1'b0 && n < 2000);
    cyc = int'(($time - t0) / 10);
    if (n >= 2000) begin
      mismatches++;
      end_sim();
    end
  endtask

  task automatic ins(input logic [7:0] b);
    bus(1'b1, A_CMD, b);
    wait_idle();
  endtask

  initial begin
    presetn = 1'b0;
    mismatches = 0;
    check_count = 0;
    t0 = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk(32'(common_count), 32'(cli_pkg::COMMON_8));
    chk(32'(display_on), 32'h0000_0000);
    bus(1'b0, A_MODE, 8'h00);
    chk(rd & 32'h0000_00FF, 32'h0000_0084);
    $display("reset test done");
    foreach (rows[i]) begin
      ins(rows[i].ins);
      bus(1'b0, rows[i].addr, 8'h00);
      chk(32'(rd[7:0] & rows[i].mask), 32'(rows[i].exp));
      $display("row %0d done", i);
    end
    // Busy length, long and short instructions.
    t0 = $time;
    bus(1'b1, A_CMD, 8'h01);
    bus(1'b0, A_CMD, 8'h00);
    chk(32'(rd[7]), 32'h0000_0001);
    wait_idle();
    chk(32'(cyc >= cli_pkg::CLEAR_TICKS * DIV), 32'h0000_0001);
    chk(32'(cyc <= cli_pkg::CLEAR_TICKS * DIV + 12), 32'h0000_0001);
    t0 = $time;
    ins(8'h0C);
    chk(32'(cyc >= cli_pkg::CMD_TICKS * DIV), 32'h0000_0001);
    chk(32'(cyc <= cli_pkg::CMD_TICKS * DIV + 12), 32'h0000_0001);
    chk(32'(display_on), 32'h0000_0001);
    $display("busy test done");
    // Data written, read back, address stepping; then glyph RAM.
    ins(8'h90);
    bus(1'b1, A_DATA, 8'h41);
    wait_idle();
    bus(1'b1, A_DATA, 8'h42);
    wait_idle();
    ins(8'h90);
    bus(1'b0, A_DATA, 8'h00);
    chk(rd, 32'h0000_0041);
    wait_idle();
    bus(1'b0, A_DATA, 8'h00);
    chk(rd, 32'h0000_0042);
    wait_idle();
    chk(rd & 32'h0000_007F, 32'h0000_0012);
    ins(8'h48);
    bus(1'b1, A_DATA, 8'h1F);
    wait_idle();
    ins(8'h48);
    bus(1'b0, A_DATA, 8'h00);
    chk(rd, 32'h0000_001F);
    wait_idle();
    $display("data test done");
    // Clear fills display memory; commons follow lines and font.
    ins(8'h01);
    ins(8'h90);
    bus(1'b0, A_DATA, 8'h00);
    chk(rd, 32'(cli_pkg::CLEAR_CODE));
    wait_idle();
    ins(8'h38);
    chk(32'(common_count), 32'(cli_pkg::COMMON_16));
    ins(8'h34);
    chk(32'(common_count), 32'(cli_pkg::COMMON_11));
    ins(8'h30);
    chk(32'(common_count), 32'(cli_pkg::COMMON_8));
    // Instruction while busy is ignored; unmapped address errs.
    bus(1'b1, A_CMD, 8'hC5);
    ins(8'h80);
    chk(rd & 32'h0000_007F, 32'h0000_0045);
    bus(1'b0, 12'h014, 8'h00);
    chk(32'(last_err), 32'h0000_0001);
    // Display shift moves the offset and home cancels it.
    ins(8'h18);
    bus(1'b0, A_STATUS, 8'h00);
    chk(rd & 32'h0000_7F00, 32'h0000_0100);
    ins(8'h1C);
    ins(8'h1F);
    bus(1'b0, A_STATUS, 8'h00);
    chk(rd & 32'h0000_7F00, 32'h0000_7F00);
    ins(8'h02);
    bus(1'b0, A_STATUS, 8'h00);
    chk(rd & 32'h0000_7F00, 32'h0000_0000);
    $display("edge test done");
    // Narrow bus: nibble pairs, fixed waits instead of polling.
    bus(1'b1, A_CMD, 8'h20);
    repeat (cli_pkg::CMD_TICKS * DIV + 20) @(posedge pclk);
    u_host.nib_write(A_CMD, 8'hA5);
    repeat (cli_pkg::CMD_TICKS * DIV + 20) @(posedge pclk);
    bus(1'b0, A_CMD, 8'h00);
    chk(rd & 32'h0000_007F, 32'h0000_0025);
    bus(1'b0, A_CMD, 8'h00);
    chk(32'(rd[7:4]), 32'h0000_0005);
    // Narrow data: one byte written in two nibbles, read back in two.
    u_host.nib_write(A_DATA, 8'h5A);
    repeat (cli_pkg::CMD_TICKS * DIV + 20) @(posedge pclk);
    u_host.nib_write(A_CMD, 8'hA5);
    repeat (cli_pkg::CMD_TICKS * DIV + 20) @(posedge pclk);
    bus(1'b0, A_DATA, 8'h00);
    chk(rd & 32'h0000_00FF, 32'h0000_005A);
    bus(1'b0, A_DATA, 8'h00);
    chk(rd & 32'h0000_00F0, 32'h0000_00A0);
    repeat (cli_pkg::CMD_TICKS * DIV + 20) @(posedge pclk);
    bus(1'b0, A_CMD, 8'h00);
    chk(rd & 32'h0000_007F, 32'h0000_0026);
    bus(1'b0, A_CMD, 8'h00);
    chk(32'(rd[7:4]), 32'h0000_0006);
    $display("nibble test done");
    end_sim();
  end
endmodule
